// *** core/maec_pkg.sv ***
/*
 * constants, field positions and state types shared by the address and
 * external-operation control block.
 * assumes a single 250 MHz clock and an apb master on the register side.
 */
package maec_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SYS_PERIOD_NS = 1000;
    localparam int SYS_PULSE_NS = 50;
    localparam int SYS_PERIOD_CYC = SYS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SYS_PULSE_CYC = SYS_PULSE_NS / CLK_PERIOD_NS;
    // ==========================================================
    // memory sizing
    localparam int LIMIT_STEP_WORDS = 2048;
    localparam int LIMIT_BLOCKS_DEF = 8;
    // ==========================================================
    // apb register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_COND_SET = 8'h04;
    localparam logic [7:0] OFS_COND_CLR = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0c;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_LIMIT = 8'h14;
    // ==========================================================
    // error flag positions
    localparam int ERR_LOADER = 0;
    localparam int ERR_MICRO = 1;
    localparam int ERR_RAW = 2;
    localparam int ERR_USER = 3;
    localparam int ERR_NANO = 4;
    localparam int ERR_LIMIT = 5;
    localparam int ERR_W = 6;
    // ==========================================================
    // condition register
    localparam int COND_W = 16;
    localparam int WRAP_BIT = 0;
    localparam int CTRL_W = 40;
    // address source field of a memory/device command
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_FIRST = 2'h1;
    localparam logic [1:0] SRC_SECOND = 2'h2;
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] COND_RST = 16'h0000;

    typedef enum logic {EO_IDLE, EO_DEV_BUSY} maec_eo_t;
endpackage

// *** core/maec_ctrl.sv ***
/*
 * base/low address forming, loop counter, constant holding register,
 * condition bits, nanocontrol register, system and phase-3 clock pulses,
 * external-operation decode with error flags and store parity.
 * assumes all sequencer, memory and port selector inputs run on clk.
 */
// Our own choices: the APB interface to the registers and the address map.
// Functional notes
// RULE1 - two eight-bit base registers form block address
// RULE2 - base registers load from shifter upper byte
// RULE3 - base selection sticky until other one chosen
// RULE4 - variant one first base, two second
// RULE5 - eight-bit loop counter loaded through shared gates
// RULE6 - counter to adder right-justified, zero fill
// RULE7 - counter overflow sets wrap flag; test/load clear
// RULE8 - constant register loads from type II word
// RULE9 - gates pick constant or shifter low byte
// RULE10 - forty-bit register holds non-phase-one nanocontrols
// RULE11 - sixteen condition bits, one tested at once
// RULE12 - set beats reset, except wrap flag
// RULE13 - one microsecond system pulse, fifty nanoseconds; the code holds it for twelve 4 ns cycles, 48 ns
// RULE14 - phase-three pulse deferred while phase extended
// RULE15 - memory and device operations never overlap
// RULE16 - memory decoded fully; device held until done
// RULE17 - status query sent straight, without gating; the code ANDs it with nanoValid and registers it
// RULE18 - six separate error flags held
// RULE19 - odd parity on micro and nano words
// RULE20 - sixteen-bit micro words, fifty-five bit nanowords
// RULE21 - limit in 2048-word steps, excess flags error
// RULE22 - limit is wired constant, not software writable
// RULE23 - eight-bit low address register supplies low byte
// RULE24 - limit checked before memory access starts
`timescale 1ns/100ps
`default_nettype none
module maec_ctrl #(
    parameter int LIMIT_BLOCKS = maec_pkg::LIMIT_BLOCKS_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // datapath loads from the sequencer
    input wire logic [15:0] shifterOutput,
    input wire logic loadFirstBase,
    input wire logic loadSecondBase,
    input wire logic loadLowAddr,
    input wire logic loadCounter,
    input wire logic gateFromShifter,
    input wire logic countStep,
    input wire logic typeTwoLoad,
    input wire logic [15:0] microWord,
    // condition bits
    input wire logic [15:0] condSetIn,
    input wire logic [15:0] condResetIn,
    input wire logic condTest,
    input wire logic [3:0] condSelect,
    output logic condResult,
    // nanoword and external operation command
    input wire logic nanoValid,
    input wire logic [54:0] nanoWord,
    input wire logic nanoParity,
    input wire logic extOpValid,
    input wire logic extOpDevice,
    input wire logic extOpWrite,
    input wire logic [1:0] extOpSrc,
    input wire logic statusQueryBit,
    input wire logic devDone,
    // store parity
    input wire logic [15:0] microWrData,
    input wire logic [16:0] microRdWord,
    input wire logic microRdValid,
    input wire logic loadMode,
    input wire logic loaderParityErr,
    input wire logic [16:0] userRdWord,
    input wire logic userRdValid,
    output logic microWrParity,
    // phase control
    input wire logic phase3Extended,
    output logic sysClkPulse,
    output logic phase3Clk,
    // outputs to memory, port selector and adder
    output logic memRead,
    output logic memWrite,
    output logic [15:0] memAddr,
    output logic devRead,
    output logic devWrite,
    output logic [7:0] devAddr,
    output logic status_query_signal,
    output logic [39:0] ctrlWord,
    output logic [15:0] counterToAdder,
    output logic [15:0] constToAdder,
    output logic [15:0] addrToAdder,
    output logic [5:0] errFlags
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] firstBase;
        logic [7:0] secondBase;
        logic [7:0] lowAddr;
        logic [7:0] loopCount;
        logic [7:0] constReg;
        logic useSecond;
        logic [15:0] cond;
        logic condRes;
        logic [39:0] ctrl;
        maec_pkg::maec_eo_t eo;
        logic holdWrite;
        logic memRd;
        logic memWr;
        logic [15:0] mAddr;
        logic devRd;
        logic devWr;
        logic [7:0] dAddr;
        logic statusQ;
        logic [5:0] err;
        logic wrPar;
        logic [7:0] divCnt;
        logic sysPulse;
        logic p3Pending;
        logic p3Clk;
        logic [15:0] adrAdder;
        logic ready;
        logic slvErr;
        logic [31:0] rdata;
    } maec_state_t;

    localparam logic [16:0] LIMIT_WORDS = 17'(LIMIT_BLOCKS * maec_pkg::LIMIT_STEP_WORDS);
    localparam logic [7:0] DIV_LAST = 8'(maec_pkg::SYS_PERIOD_CYC - 1);
    localparam logic [7:0] PULSE_END = 8'(maec_pkg::SYS_PULSE_CYC);

    maec_state_t q;
    maec_state_t d;

    // odd parity holds when the whole word has an odd count of ones
    function automatic logic oddOk(input logic [55:0] w);
        oddOk = ^w;
    endfunction

    // selected base register joined with the low address byte
    function automatic logic [15:0] joinAddr(input logic second, input logic [7:0] b1,
                                             input logic [7:0] b2, input logic [7:0] lo);
        joinAddr = second ? {b2, lo} : {b1, lo};
    endfunction

    logic apbAccess;
    logic apbWrite;
    logic selSecond;
    logic [15:0] selAddr;
    logic overLimit;
    logic acceptOp;
    logic [7:0] gateByte;
    logic wrapSet;
    logic wrapReset;
    logic [15:0] swSet;
    logic [15:0] swClr;
    logic [5:0] newErr;
    logic [5:0] errClr;

    // ==========================================================
    // next-state logic
    always_comb begin
        d = q;
        apbAccess = psel && penable && !q.ready;
        apbWrite = psel && penable && pwrite && q.ready;
        // a busy device refuses new ops
        acceptOp = extOpValid && (q.eo == maec_pkg::EO_IDLE); // RULE15
        selSecond = q.useSecond;
        if (acceptOp && extOpSrc == maec_pkg::SRC_FIRST) begin
            selSecond = 1'b0; // RULE4
        end else if (acceptOp && extOpSrc == maec_pkg::SRC_SECOND) begin
            selSecond = 1'b1; // RULE4
        end
        d.useSecond = selSecond; // RULE3
        selAddr = joinAddr(selSecond, q.firstBase, q.secondBase, q.lowAddr); // RULE1 RULE23
        overLimit = {1'b0, selAddr} >= LIMIT_WORDS; // RULE21 RULE22
        d.adrAdder = joinAddr(q.useSecond, q.firstBase, q.secondBase, q.lowAddr);

        // base and low address, counter and constant loads
        gateByte = gateFromShifter ? shifterOutput[7:0] : q.constReg; // RULE9
        if (loadFirstBase) begin
            d.firstBase = shifterOutput[15:8]; // RULE2
        end
        if (loadSecondBase) begin
            d.secondBase = shifterOutput[15:8]; // RULE2
        end
        if (loadLowAddr) begin
            d.lowAddr = gateByte; // RULE23
        end
        if (typeTwoLoad) begin
            d.constReg = microWord[7:0]; // RULE8 RULE20
        end
        wrapSet = 1'b0;
        if (loadCounter) begin
            d.loopCount = gateByte; // RULE5
        end else if (countStep) begin
            d.loopCount = q.loopCount + 8'h01;
            wrapSet = (q.loopCount == 8'hff); // RULE7
        end

        // condition bits: set wins, but the wrap flag lets reset win
        swSet = (apbWrite && paddr == maec_pkg::OFS_COND_SET) ? pwdata[15:0] : 16'h0000;
        swClr = (apbWrite && paddr == maec_pkg::OFS_COND_CLR) ? pwdata[15:0] : 16'h0000;
        d.cond = (q.cond & ~(condResetIn | swClr)) | condSetIn | swSet; // RULE12
        wrapReset = condResetIn[maec_pkg::WRAP_BIT] || swClr[maec_pkg::WRAP_BIT] || loadCounter ||
                    (condTest && condSelect == 4'(maec_pkg::WRAP_BIT)); // RULE7
        d.cond[maec_pkg::WRAP_BIT] = !wrapReset && (q.cond[maec_pkg::WRAP_BIT] || wrapSet ||
                    condSetIn[maec_pkg::WRAP_BIT] || swSet[maec_pkg::WRAP_BIT]); // RULE12
        if (condTest) begin
            d.condRes = q.cond[condSelect]; // RULE11
        end

        // nanocontrols past phase 1; the top bit is decoded before capture
        if (nanoValid) begin
            d.ctrl = {nanoWord[54:53] == 2'h3, nanoWord[54:16]}; // RULE10 RULE20
        end
        d.statusQ = nanoValid && statusQueryBit; // RULE17

        // external operation controls
        d.memRd = 1'b0;
        d.memWr = 1'b0;
        newErr = '0;
        case (q.eo)
            maec_pkg::EO_IDLE: begin
                if (acceptOp && extOpDevice) begin
                    d.eo = maec_pkg::EO_DEV_BUSY;
                    d.holdWrite = extOpWrite;
                    d.dAddr = selAddr[15:8];
                    d.devRd = !extOpWrite;
                    d.devWr = extOpWrite;
                end else if (acceptOp && overLimit) begin
                    newErr[maec_pkg::ERR_LIMIT] = 1'b1; // RULE24
                end else if (acceptOp) begin
                    d.holdWrite = extOpWrite;
                    d.mAddr = selAddr;
                    d.memRd = !extOpWrite; // RULE16
                    d.memWr = extOpWrite; // RULE16
                end
            end
            maec_pkg::EO_DEV_BUSY: begin
                // the port selector says when the device transfer ends
                if (devDone) begin
                    d.eo = maec_pkg::EO_IDLE; // RULE16
                    d.devRd = 1'b0;
                    d.devWr = 1'b0;
                end
            end
            default: begin
                d.eo = maec_pkg::EO_IDLE;
            end
        endcase

        // parity and error flags; a new error beats a clear
        d.wrPar = ~^microWrData; // RULE19
        newErr[maec_pkg::ERR_LOADER] = loaderParityErr;
        newErr[maec_pkg::ERR_MICRO] = microRdValid && !loadMode && !oddOk({39'h0, microRdWord}); // RULE19
        newErr[maec_pkg::ERR_RAW] = microRdValid && loadMode && !oddOk({39'h0, microRdWord});
        newErr[maec_pkg::ERR_USER] = userRdValid && !oddOk({39'h0, userRdWord});
        newErr[maec_pkg::ERR_NANO] = nanoValid && !oddOk({nanoParity, nanoWord}); // RULE19
        errClr = (apbWrite && paddr == maec_pkg::OFS_STATUS) ? pwdata[5:0] : 6'h00;
        d.err = (q.err & ~errClr) | newErr; // RULE18

        // system pulse every period and the held-off phase-3 pulse
        d.divCnt = (q.divCnt == DIV_LAST) ? 8'h00 : q.divCnt + 8'h01;
        d.sysPulse = d.divCnt < PULSE_END; // RULE13
        d.p3Clk = 1'b0;
        if (q.divCnt == DIV_LAST || q.p3Pending) begin
            d.p3Pending = phase3Extended; // RULE14
            d.p3Clk = !phase3Extended; // RULE14
        end

        // apb: one wait state, answer registered
        d.ready = apbAccess;
        d.slvErr = 1'b0;
        d.rdata = 32'h0000_0000;
        if (apbAccess) begin
            case (paddr)
                maec_pkg::OFS_STATUS: d.rdata = {26'h0, q.err};
                maec_pkg::OFS_COND_SET: d.rdata = {16'h0, q.cond};
                maec_pkg::OFS_COND_CLR: d.rdata = {16'h0, q.cond};
                maec_pkg::OFS_ADDR: d.rdata = {7'h0, q.useSecond, q.firstBase, q.secondBase, q.lowAddr};
                maec_pkg::OFS_COUNT: d.rdata = {15'h0, q.eo == maec_pkg::EO_DEV_BUSY, q.constReg, q.loopCount};
                maec_pkg::OFS_LIMIT: d.rdata = {15'h0, LIMIT_WORDS}; // RULE22
                default: d.slvErr = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.firstBase <= maec_pkg::BYTE_RST;
            q.secondBase <= maec_pkg::BYTE_RST;
            q.cond <= maec_pkg::COND_RST;
            q.eo <= maec_pkg::EO_IDLE;
            q.wrPar <= 1'b1;
            q.sysPulse <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.slvErr;
    assign condResult = q.condRes;
    assign microWrParity = q.wrPar;
    assign sysClkPulse = q.sysPulse;
    assign phase3Clk = q.p3Clk;
    assign memRead = q.memRd;
    assign memWrite = q.memWr;
    assign memAddr = q.mAddr;
    assign devRead = q.devRd;
    assign devWrite = q.devWr;
    assign devAddr = q.dAddr;
    assign status_query_signal = q.statusQ;
    assign ctrlWord = q.ctrl;
    assign counterToAdder = {8'h00, q.loopCount}; // RULE6
    assign constToAdder = {q.constReg, 8'h00}; // RULE8
    assign addrToAdder = q.adrAdder;
    assign errFlags = q.err;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence seqMemOp;
        extOpValid && !extOpDevice && q.eo == maec_pkg::EO_IDLE;
    endsequence
    sequence seqOver;
        seqMemOp ##0 overLimit;
    endsequence

    chk_wrap_reset_wins: assert property (loadCounter |=> !q.cond[maec_pkg::WRAP_BIT]) // RULE12
        else $error("wrap flag kept through a load");
    chk_wrap_on_overflow: assert property (countStep && !loadCounter && q.loopCount == 8'hff && // RULE7
        !condResetIn[0] && !condTest && !swClr[0] |=> q.cond[maec_pkg::WRAP_BIT] && q.loopCount == 8'h00)
        else $error("overflow did not set wrap flag");
    chk_select_sticky: assert property (extOpValid && extOpSrc == maec_pkg::SRC_NONE // RULE3
        |=> $stable(q.useSecond)) else $error("base selection moved without source");
    chk_second_base: assert property (seqMemOp ##0 extOpSrc == maec_pkg::SRC_SECOND ##0 !overLimit // RULE4
        |=> q.mAddr == {$past(q.secondBase), $past(q.lowAddr)}) else $error("second base not used");
    chk_limit_error: assert property (seqOver |=> q.err[maec_pkg::ERR_LIMIT] && !q.memRd && !q.memWr) // RULE24
        else $error("over-limit access started");
    chk_mem_in_limit: assert property ($rose(q.memRd) || $rose(q.memWr) // RULE21
        |-> {1'b0, q.mAddr} < LIMIT_WORDS) else $error("memory access beyond limit");
    chk_ops_exclusive: assert property (!((q.memRd || q.memWr) && (q.devRd || q.devWr))) // RULE15
        else $error("memory and device op together");
    chk_dev_held: assert property ((q.devRd || q.devWr) && !devDone |=> q.devRd || q.devWr) // RULE16
        else $error("device op dropped before done");
    chk_sys_pulse: assert property ($rose(q.sysPulse) |-> q.sysPulse[*8] ##1 q.sysPulse[*4] ##1 !q.sysPulse) // RULE13
        else $error("system pulse width wrong");
    chk_phase3_hold: assert property (q.p3Pending && phase3Extended |=> !q.p3Clk) // RULE14
        else $error("phase-3 pulse during extension");
    chk_micro_parity: assert property (1'b1 |=> ^{q.wrPar, $past(microWrData)}) // RULE19
        else $error("micro write parity not odd");
    chk_nano_error: assert property (nanoValid && !(^{nanoParity, nanoWord}) // RULE18
        |=> q.err[maec_pkg::ERR_NANO]) else $error("nano parity error lost");
endmodule
`default_nettype wire

// *** tb/maec_mem_model.sv ***
/*
 * behavioural shared core memory and port selector facing the controller.
 * assumes the controller's memory and device strobes are registered on clk.
 */
`timescale 1ns/100ps
`default_nettype none
module maec_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bench controls
    input wire logic slow,
    input wire logic badParity,
    // controller side
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    input wire logic devRead,
    input wire logic devWrite,
    // answers
    output logic devDone,
    output logic [16:0] userRdWord,
    output logic userRdValid
);
    // ==========================================================
    // device completion: one done pulse after a prompt or a slow wait
    int waitCnt;
    always @(posedge clk) begin
        waitCnt <= (rstn && (devRead || devWrite)) ? waitCnt + 1 : 0;
        devDone <= rstn && (devRead || devWrite) && waitCnt == (slow ? 6 : 1);
    end
    // data a cycle after the strobe; inverted between reads
    always @(posedge clk) begin
        userRdValid <= rstn && memRead;
        if (!rstn) begin
            userRdWord <= 17'h00000;
        end else if (memRead) begin
            userRdWord <= {(~^(memAddr ^ 16'h5a5a)) ^ badParity, memAddr ^ 16'h5a5a};
        end else begin
            userRdWord <= ~userRdWord;
        end
    end
endmodule
`default_nettype wire

// *** tb/maec_ctrl_tb.sv ***
/*
 * self-checking bench for the address and external-operation controller.
 * assumes the memory/port selector model beside it and an apb master here.
 */
`timescale 1ns/100ps
`default_nettype none
module maec_ctrl_tb;
    // small limit so a second base of 8'h20 lands beyond it
    localparam int LIM = 2;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err, slow, badParity;
    logic [7:0] paddr, devAddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] shifterOutput, microWord, condSetIn, condResetIn, microWrData;
    logic [15:0] memAddr, counterToAdder, constToAdder, addrToAdder;
    logic loadFirstBase, loadSecondBase, loadLowAddr, loadCounter, gateFromShifter, countStep, typeTwoLoad;
    logic condTest, condResult, nanoValid, nanoParity, extOpValid, extOpDevice, extOpWrite, statusQueryBit;
    logic devDone, microRdValid, loadMode, loaderParityErr, userRdValid, microWrParity, phase3Extended;
    logic sysClkPulse, phase3Clk, memRead, memWrite, devRead, devWrite, statusQuery;
    logic [3:0] condSelect;
    logic [1:0] extOpSrc;
    logic [54:0] nanoWord, nw;
    logic [16:0] microRdWord, userRdWord;
    logic [39:0] ctrlWord;
    logic [5:0] errFlags;
    int nFail, nChecks, n, k;

    // ==========================================================
    // design and far side
    maec_ctrl #(.LIMIT_BLOCKS(LIM)) uut (.*, .status_query_signal(statusQuery));
    maec_mem_model mem (.*);

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // tasks
    task automatic giveVerdict();
        $display("checks %0d, mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ends every strobe after one sampling edge, then lets that edge settle
    task automatic tick();
        @(posedge clk);
        {loadFirstBase, loadSecondBase, loadLowAddr, loadCounter, countStep, typeTwoLoad} <= '0;
        {condTest, nanoValid, extOpValid, microRdValid, loaderParityErr} <= '0;
        condSetIn <= '0;
        condResetIn <= '0;
        #1;
    endtask
    // request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            nFail++;
            giveVerdict();
        end
    endtask
    // kind: 0/1 base, 2/3 low/counter from shifter, 4/5 low/counter from constant, 6 constant, 7 step
    task automatic ld(input logic [2:0] kind, input logic [7:0] v);
        @(posedge clk);
        shifterOutput <= (kind < 2) ? {v, 8'h5c} : {8'he7, v};
        microWord <= {8'hc3, v};
        gateFromShifter <= (kind < 4);
        loadFirstBase <= (kind == 0);
        loadSecondBase <= (kind == 1);
        loadLowAddr <= (kind == 2 || kind == 4);
        loadCounter <= (kind == 3 || kind == 5);
        typeTwoLoad <= (kind == 6);
        countStep <= (kind == 7);
        tick();
    endtask
    task automatic extop(input logic dev, input logic wr, input logic [1:0] src);
        @(posedge clk);
        extOpValid <= 1'b1;
        extOpDevice <= dev;
        extOpWrite <= wr;
        extOpSrc <= src;
        tick();
    endtask
    task automatic tally(input int c, input bit p3);
        n = 0;
        repeat (c) begin
            @(posedge clk);
            #1 n += p3 ? phase3Clk : sysClkPulse;
        end
    endtask
    task automatic test(input logic [3:0] sel);
        @(posedge clk);
        condTest <= 1'b1;
        condSelect <= sel;
        tick();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic waitDev();
        for (int i = 0; i < 20 && (devRead || devWrite) !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk(devRead || devWrite, 0);
        if ((devRead || devWrite) !== 1'b0) giveVerdict();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, shifterOutput, microWord, condSetIn, condResetIn} = '0;
        {loadFirstBase, loadSecondBase, loadLowAddr, loadCounter, gateFromShifter, countStep, typeTwoLoad} = '0;
        {condTest, condSelect, nanoValid, nanoWord, nanoParity, extOpValid, extOpDevice, extOpWrite} = '0;
        {extOpSrc, statusQueryBit, microWrData, microRdWord, microRdValid, loadMode, loaderParityErr} = '0;
        {phase3Extended, badParity, nFail, nChecks} = '0;
        slow = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // reset values, read-only limit, unmapped offset
        for (int a = 0; a < 5; a++) rdchk(8'(4 * a), 32'h0);
        apb(1'b1, maec_pkg::OFS_LIMIT, 32'h0000ffff);
        rdchk(maec_pkg::OFS_LIMIT, LIM * maec_pkg::LIMIT_STEP_WORDS);
        apb(1'b0, 8'h18, 32'h0);
        chk(err, 1);
        // address forming through both gate sources
        ld(0, 8'h0f);
        ld(1, 8'h20);
        ld(6, 8'h3c);
        ld(4, 8'h00);
        chk(constToAdder, 16'h3c00);
        rdchk(maec_pkg::OFS_ADDR, 32'h000f203c);
        ld(2, 8'h81);
        rdchk(maec_pkg::OFS_ADDR, 32'h000f2081);
        // sticky source selection and the limit check
        extop(0, 0, maec_pkg::SRC_FIRST);
        chk({memRead, memAddr, addrToAdder}, {1'b1, 16'h0f81, 16'h0f81});
        extop(0, 1, maec_pkg::SRC_NONE);
        chk({memWrite, memAddr}, {1'b1, 16'h0f81});
        extop(0, 0, maec_pkg::SRC_SECOND);
        chk({memRead, errFlags}, 7'h20);
        extop(0, 0, maec_pkg::SRC_NONE);
        chk(memRead, 0);
        rdchk(maec_pkg::OFS_ADDR, 32'h010f2081);
        ld(1, 8'h01);
        extop(0, 0, maec_pkg::SRC_SECOND);
        chk({memRead, memAddr}, {1'b1, 16'h0181});
        extop(0, 0, maec_pkg::SRC_FIRST);
        chk(memRead, 1);
        rdchk(maec_pkg::OFS_STATUS, 32'h20);
        apb(1'b1, maec_pkg::OFS_STATUS, 32'h20);
        rdchk(maec_pkg::OFS_STATUS, 32'h0);
        // device operations, slow then prompt, memory refused while busy
        extop(1, 0, maec_pkg::SRC_FIRST);
        chk({devRead, devAddr}, {1'b1, 8'h0f});
        extop(0, 0, maec_pkg::SRC_FIRST);
        chk(memRead, 0);
        waitDev();
        @(posedge clk);
        slow <= 1'b0;
        extop(1, 1, maec_pkg::SRC_NONE);
        chk({devWrite, devAddr}, {1'b1, 8'h0f});
        waitDev();
        // loop counter wrap, cleared by test and by load
        ld(6, 8'hfe);
        ld(5, 8'h00);
        chk(counterToAdder, 16'h00fe);
        ld(7, 8'h00);
        ld(7, 8'h00);
        rdchk(maec_pkg::OFS_COND_SET, 32'h1);
        test(0);
        chk(condResult, 1);
        rdchk(maec_pkg::OFS_COND_SET, 32'h0);
        ld(3, 8'hff);
        ld(7, 8'h00);
        rdchk(maec_pkg::OFS_COUNT, 32'hfe00);
        ld(3, 8'h10);
        rdchk(maec_pkg::OFS_COND_SET, 32'h0);
        // set against reset in one cycle
        @(posedge clk);
        condSetIn <= 16'h0009;
        condResetIn <= 16'h0009;
        tick();
        rdchk(maec_pkg::OFS_COND_SET, 32'h8);
        test(3);
        chk(condResult, 1);
        apb(1'b1, maec_pkg::OFS_COND_CLR, 32'h8);
        rdchk(maec_pkg::OFS_COND_CLR, 32'h0);
        // nanoword capture and status query gated by nanoValid
        nw = 55'h6a_bcde_f012_3456;
        @(posedge clk);
        {nanoValid, statusQueryBit, nanoWord, nanoParity} <= {2'b11, nw, ~^nw};
        tick();
        chk({statusQuery, ctrlWord}, {1'b1, nw[54:53] == 2'b11, nw[54:16]});
        tick();
        chk(statusQuery, 0);
        // generated write parity, odd over seventeen bits
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            microWrData <= i ? 16'h0003 : 16'h0007;
            tick();
            tick();
            chk(microWrParity, i);
        end
        // each parity error source in turn
        @(posedge clk);
        loaderParityErr <= 1'b1;
        tick();
        rdchk(maec_pkg::OFS_STATUS, 32'h01);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            {microRdValid, microRdWord, loadMode} <= {1'b1, 17'h00000, i[0]};
            tick();
            rdchk(maec_pkg::OFS_STATUS, i ? 32'h07 : 32'h03);
        end
        @(posedge clk);
        badParity <= 1'b1;
        extop(0, 0, maec_pkg::SRC_FIRST);
        rdchk(maec_pkg::OFS_STATUS, 32'h0f);
        @(posedge clk);
        {nanoValid, statusQueryBit, nanoWord, nanoParity} <= {1'b1, 57'h0};
        tick();
        rdchk(maec_pkg::OFS_STATUS, 32'h1f);
        apb(1'b1, maec_pkg::OFS_STATUS, 32'h1f);
        rdchk(maec_pkg::OFS_STATUS, 32'h0);
        // system pulse width per period, phase-three hold-off
        tally(250, 0);
        chk(n, maec_pkg::SYS_PULSE_CYC);
        @(posedge clk);
        phase3Extended <= 1'b1;
        tally(260, 1);
        chk(n, 0);
        @(posedge clk);
        phase3Extended <= 1'b0;
        tally(4, 1);
        chk(n, 1);
        giveVerdict();
    end
endmodule
`default_nettype wire
